// File: core/clk_presc_pkg.sv
// Constants shared by the system clock prescaler and trim block
package clk_presc_pkg;
  localparam logic [7:0] CTRL_IDX = 8'h61;
  localparam logic [7:0] TRIM_IDX = 8'h62;
  localparam logic [7:0] ASYNC_IDX = 8'h63;
  localparam logic [11:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
  localparam logic [11:0] TRIM_ADDR = {2'h0, TRIM_IDX, 2'h0};
  localparam logic [11:0] ASYNC_ADDR = {2'h0, ASYNC_IDX, 2'h0};
  localparam int UNLOCK_BIT = 7;
  localparam int SEL_MSB = 3;
  localparam int TIMER_EXTERNAL_CLOCK_SELECT_BIT = 0;
  localparam logic [7:0] UNLOCK_KEY = 8'h80;
  localparam logic [3:0] SEL_RESET_FUSE_PROG = 4'h3;
  localparam logic [3:0] SEL_RESET_FUSE_UNPROG = 4'h0;
  localparam logic [3:0] SEL_MAX = 4'h8;
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  localparam logic [7:0] TRIM_RESET = 8'h00;
endpackage

// File: core/system_clock_prescaler_trim.sv
// System clock prescaler with timed unlock, clock output pin and RC trim register
`timescale 1ns/10ps
module system_clock_prescaler_trim
  import clk_presc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic divide_by_eight_fuse,
  input wire logic clock_output_fuse,
  input wire logic [7:0] factory_trim,
  input wire logic port_pin_o,
  input wire logic port_pin_oe,
  output logic clock_output_pin_o,
  output logic clock_output_pin_oe,
  output logic cpu_clock_en,
  output logic flash_clock_en,
  output logic io_clock_en,
  output logic converter_clock_en,
  output logic [7:0] trim_value,
  output logic trim_range_bit,
  output logic [6:0] trim_fine_value,
  input wire logic timer_osc_input_pin,
  input wire logic timer_crystal_clock,
  output logic timer_clock_source,
  output logic timer_external_clock_select
);

  // Count limit for a select code; reserved codes behave as the largest factor
  function automatic logic [7:0] div_limit(input logic [3:0] s);
    logic [8:0] f;
    f = 9'h001 << s;
    if (s > SEL_MAX) begin
      div_limit = 8'hff;
    end else begin
      div_limit = f[7:0] - 8'h01;
    end
  endfunction

  logic loaded_q;
  logic unlock_q, unlock_d;
  logic [2:0] unl_cnt_q, unl_cnt_d;
  logic [3:0] pend_sel_q, pend_sel_d;
  logic [3:0] act_sel_q, act_sel_d;
  logic [7:0] cnt_q, cnt_d;
  logic tick_q;
  logic phase_q;
  logic [7:0] trim_q, trim_d;
  logic ext_sel_q, ext_sel_d;
  logic [31:0] prdata_q;
  logic pslverr_q;

  wire setup_w = psel & ~penable;
  wire wr_w = psel & penable & pwrite & pstrb[0];
  wire ctrl_hit_w = paddr == CTRL_ADDR;
  wire trim_hit_w = paddr == TRIM_ADDR;
  wire async_hit_w = paddr == ASYNC_ADDR;
  wire mapped_w = ctrl_hit_w | trim_hit_w | async_hit_w;
  wire ctrl_wr_w = wr_w & ctrl_hit_w;
  wire key_wr_w = ctrl_wr_w & (pwdata[7:0] == UNLOCK_KEY);
  wire sel_wr_w = ctrl_wr_w & ~pwdata[UNLOCK_BIT];
  wire [3:0] fuse_sel_w = divide_by_eight_fuse ? SEL_RESET_FUSE_PROG : SEL_RESET_FUSE_UNPROG;
  wire [7:0] lim_w = div_limit(act_sel_q);
  wire wrap_w = cnt_q == lim_w;
  wire [7:0] lim_next_w = div_limit(act_sel_d);
  wire phase_d = cnt_d <= {1'b0, lim_next_w[7:1]};
  wire [7:0] ctrl_rd_w = {unlock_q, 3'h0, pend_sel_q};
  wire [7:0] rd_mux_w = ctrl_hit_w ? ctrl_rd_w :
                        trim_hit_w ? trim_q :
                        async_hit_w ? {7'h00, ext_sel_q} : 8'h00;

  // Unlock window: key write opens it, timeout or select write closes it
  always_comb begin
    unlock_d = unlock_q;
    unl_cnt_d = unl_cnt_q;
    pend_sel_d = pend_sel_q;
    if (!loaded_q) begin
      pend_sel_d = fuse_sel_w;
    end else if (unlock_q) begin
      if (sel_wr_w) begin
        pend_sel_d = pwdata[SEL_MSB:0];
        unlock_d = 1'b0;
      end else if (unl_cnt_q == 3'h0) begin
        unlock_d = 1'b0;
      end else begin
        unl_cnt_d = unl_cnt_q - 3'h1;
      end
    end else if (key_wr_w) begin
      unlock_d = 1'b1;
      unl_cnt_d = UNLOCK_CYCLES - 3'h1;
    end
  end

  // Active setting moves only when the running period ends
  always_comb begin
    act_sel_d = act_sel_q;
    if (!loaded_q) begin
      act_sel_d = fuse_sel_w;
    end else if (wrap_w) begin
      act_sel_d = pend_sel_q;
    end
    cnt_d = wrap_w ? 8'h00 : cnt_q + 8'h01;
  end

  always_comb begin
    trim_d = trim_q;
    ext_sel_d = ext_sel_q;
    if (!loaded_q) begin
      trim_d = factory_trim;
    end else if (wr_w & trim_hit_w) begin
      trim_d = pwdata[7:0];
    end
    if (wr_w & async_hit_w) begin
      ext_sel_d = pwdata[TIMER_EXTERNAL_CLOCK_SELECT_BIT];
    end
  end

  // Fuse and factory values are taken at the first edge after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loaded_q <= 1'b0;
      unlock_q <= 1'b0;
      unl_cnt_q <= 3'h0;
      pend_sel_q <= SEL_RESET_FUSE_UNPROG;
      act_sel_q <= SEL_RESET_FUSE_UNPROG;
      trim_q <= TRIM_RESET;
      ext_sel_q <= 1'b0;
    end else begin
      loaded_q <= 1'b1;
      unlock_q <= unlock_d;
      unl_cnt_q <= unl_cnt_d;
      pend_sel_q <= pend_sel_d;
      act_sel_q <= act_sel_d;
      trim_q <= trim_d;
      ext_sel_q <= ext_sel_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
      tick_q <= 1'b0;
      phase_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= wrap_w;
      phase_q <= phase_d;
    end
  end

  // Read data is captured in setup, so the slave answers with no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup_w) begin
      prdata_q <= {24'h00_0000, rd_mux_w};
      pslverr_q <= ~mapped_w;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = pslverr_q & psel & penable;

  // All synchronous domains share one enable so they stay in step
  assign cpu_clock_en = tick_q;
  assign flash_clock_en = tick_q;
  assign io_clock_en = tick_q;
  assign converter_clock_en = tick_q;

  // Fuse is a static level, so the override also holds while in reset
  assign clock_output_pin_oe = clock_output_fuse | port_pin_oe;
  assign clock_output_pin_o = clock_output_fuse ? phase_q : port_pin_o;

  assign trim_value = trim_q;
  assign trim_range_bit = trim_q[7];
  assign trim_fine_value = trim_q[6:0];

  assign timer_external_clock_select = ext_sel_q;
  assign timer_clock_source = ext_sel_q ? timer_osc_input_pin : timer_crystal_clock;

  a_unlock_key_set: assert property (@(posedge pclk) disable iff (!presetn)
    loaded_q && !unlock_q && key_wr_w |=> unlock_q)
    else $error("unlock not set by key write");

  a_unlock_bad_key: assert property (@(posedge pclk) disable iff (!presetn)
    loaded_q && !unlock_q && !key_wr_w |=> !unlock_q)
    else $error("unlock set without key write");

  a_unlock_timeout: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(unlock_q) |-> ##[1:4] !unlock_q)
    else $error("unlock window too long");

  a_unlock_full_window: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(unlock_q) && !sel_wr_w ##1 !sel_wr_w ##1 !sel_wr_w ##1 !sel_wr_w |-> unlock_q)
    else $error("unlock window closed early");

  a_rewrite_no_extend: assert property (@(posedge pclk) disable iff (!presetn)
    unlock_q && key_wr_w && unl_cnt_q != 3'h0 |=> unlock_q && unl_cnt_q == $past(unl_cnt_q) - 3'h1)
    else $error("unlock rewrite changed window");

  a_locked_sel_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    loaded_q && !unlock_q && ctrl_wr_w |=> $stable(pend_sel_q))
    else $error("locked write changed select");

  a_unlocked_sel_taken: assert property (@(posedge pclk) disable iff (!presetn)
    loaded_q && unlock_q && sel_wr_w |=> pend_sel_q == $past(pwdata[3:0]) && !unlock_q)
    else $error("select write not taken");

  a_switch_on_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    loaded_q && !wrap_w |=> $stable(act_sel_q))
    else $error("setting changed mid period");

  a_count_bounded: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_q <= div_limit(act_sel_q))
    else $error("prescaler count out of range");

  a_reset_fuse_load: assert property (@(posedge pclk) disable iff (!presetn)
    !loaded_q |=> act_sel_q == $past(fuse_sel_w) && trim_q == $past(factory_trim))
    else $error("reset values not loaded");

  a_pin_override: assert property (@(posedge pclk) disable iff (!presetn)
    clock_output_fuse |-> clock_output_pin_oe && clock_output_pin_o == phase_q)
    else $error("clock pin not overridden");

  a_reserved_read: assert property (@(posedge pclk) disable iff (!presetn)
    setup_w && ctrl_hit_w |=> prdata[6:4] == 3'h0)
    else $error("reserved control bits nonzero");

  // Domain enables and period boundary
  a_enables_match: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_clock_en == flash_clock_en && cpu_clock_en == io_clock_en && cpu_clock_en == converter_clock_en)
    else $error("domain enables differ");

  a_tick_follows_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    wrap_w |=> cpu_clock_en)
    else $error("no enable after wrap");

  a_no_tick_mid: assert property (@(posedge pclk) disable iff (!presetn)
    !wrap_w |=> !cpu_clock_en)
    else $error("enable inside a period");

  a_cnt_wrap_zero: assert property (@(posedge pclk) disable iff (!presetn)
    wrap_w |=> cnt_q == 8'h00)
    else $error("count not restarted");

  a_cnt_step: assert property (@(posedge pclk) disable iff (!presetn)
    !wrap_w |=> cnt_q == $past(cnt_q) + 8'h01)
    else $error("count skipped a step");

  a_switch_takes_pend: assert property (@(posedge pclk) disable iff (!presetn)
    loaded_q && wrap_w |=> act_sel_q == $past(pend_sel_q))
    else $error("pending select not applied");

  // Phase lags the count by nothing once the fuse values are loaded
  a_phase_first_half: assert property (@(posedge pclk) disable iff (!presetn)
    loaded_q |-> phase_q == (cnt_q <= {1'b0, lim_w[7:1]}))
    else $error("phase out of step with count");

  a_reserved_as_max: assert property (@(posedge pclk) disable iff (!presetn)
    act_sel_q > SEL_MAX |-> lim_w == 8'hff)
    else $error("reserved code not slowest");

  a_limit_pow2: assert property (@(posedge pclk) disable iff (!presetn)
    act_sel_q <= SEL_MAX |-> lim_w == 8'((9'h001 << act_sel_q) - 9'h001))
    else $error("limit not a power of two");

  // Clock pin
  a_pin_low_end: assert property (@(posedge pclk) disable iff (!presetn)
    loaded_q && clock_output_fuse && wrap_w && lim_w != 8'h00 |-> !clock_output_pin_o)
    else $error("pin high at period end");

  a_pin_high_start: assert property (@(posedge pclk) disable iff (!presetn)
    loaded_q && clock_output_fuse && cnt_q == 8'h00 |-> clock_output_pin_o)
    else $error("pin low at period start");

  a_pin_port_mode: assert property (@(posedge pclk) disable iff (!presetn)
    !clock_output_fuse |-> clock_output_pin_o == port_pin_o && clock_output_pin_oe == port_pin_oe)
    else $error("port function not restored");

  // Unlock window, register writes and read-back
  a_pend_stable: assert property (@(posedge pclk) disable iff (!presetn)
    loaded_q && !ctrl_wr_w |=> $stable(pend_sel_q))
    else $error("select moved without write");

  a_unlock_clear_sel: assert property (@(posedge pclk) disable iff (!presetn)
    unlock_q && sel_wr_w |=> !unlock_q)
    else $error("unlock kept after select write");

  a_unlock_count_start: assert property (@(posedge pclk) disable iff (!presetn)
    loaded_q && !unlock_q && key_wr_w |=> unl_cnt_q == UNLOCK_CYCLES - 3'h1)
    else $error("unlock window wrong length");

  a_unlock_expire: assert property (@(posedge pclk) disable iff (!presetn)
    unlock_q && unl_cnt_q == 3'h0 && !sel_wr_w |=> !unlock_q)
    else $error("unlock not expired");

  a_key_while_open: assert property (@(posedge pclk) disable iff (!presetn)
    unlock_q && key_wr_w |=> $stable(pend_sel_q))
    else $error("key rewrite changed select");

  a_fuse_reset_sel: assert property (@(posedge pclk) disable iff (!presetn)
    !loaded_q |=> pend_sel_q == $past(fuse_sel_w))
    else $error("pending select not from fuse");

  a_trim_write: assert property (@(posedge pclk) disable iff (!presetn)
    loaded_q && wr_w && trim_hit_w |=> trim_q == $past(pwdata[7:0]))
    else $error("trim write not taken");

  a_trim_hold: assert property (@(posedge pclk) disable iff (!presetn)
    loaded_q && !(wr_w && trim_hit_w) |=> $stable(trim_q))
    else $error("trim changed without write");

  a_trim_fields: assert property (@(posedge pclk) disable iff (!presetn)
    {trim_range_bit, trim_fine_value} == trim_value)
    else $error("trim fields split wrongly");

  a_timer_src_mux: assert property (@(posedge pclk) disable iff (!presetn)
    timer_clock_source == (timer_external_clock_select ? timer_osc_input_pin : timer_crystal_clock))
    else $error("timer source wrong");

  a_ext_sel_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_w && async_hit_w |=> timer_external_clock_select == $past(pwdata[TIMER_EXTERNAL_CLOCK_SELECT_BIT]))
    else $error("external select write lost");

  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !mapped_w |-> pslverr)
    else $error("unmapped access without error");

  a_sel_read_pend: assert property (@(posedge pclk) disable iff (!presetn)
    setup_w && ctrl_hit_w |=> prdata[3:0] == $past(pend_sel_q))
    else $error("select read back wrong");

  a_unlock_read: assert property (@(posedge pclk) disable iff (!presetn)
    setup_w && ctrl_hit_w |=> prdata[7] == $past(unlock_q))
    else $error("unlock read back wrong");

  a_trim_read: assert property (@(posedge pclk) disable iff (!presetn)
    setup_w && trim_hit_w |=> prdata[7:0] == $past(trim_q))
    else $error("trim read back wrong");

  a_unmapped_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
    setup_w && !mapped_w |=> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");

endmodule

// File: testbench/system_clock_prescaler_trim_tb.sv
// Self-checking bench for the system clock prescaler and trim block
`timescale 1ns/10ps
module system_clock_prescaler_trim_tb;
  import clk_presc_pkg::*;
  typedef struct {logic [3:0] sel; int prd; int hi;} row_s;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, err, d8 = 1, cof = 1, ppo = 0, ppoe = 0, osc = 0, xtal = 1;
  logic [7:0] ftrim = 8'h5a, tval;
  logic pin_o, pin_oe, cpu_en, fl_en, io_en, cv_en, rbit, tsrc, text;
  logic [6:0] tfine;
  int error_cnt = 0, checks_done = 0, n, hi;
  // Big and small factors alternate so every change but the last (code 5 to 4) crosses a wide gap
  row_s rows [9] = '{'{4'h0, 1, 1}, '{4'h8, 256, 128}, '{4'h1, 2, 1}, '{4'h7, 128, 64},
    '{4'h2, 4, 2}, '{4'h6, 64, 32}, '{4'h3, 8, 4}, '{4'h5, 32, 16}, '{4'h4, 16, 8}};
  always #5 pclk = ~pclk;
  system_clock_prescaler_trim system_clock_prescaler_trim_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .divide_by_eight_fuse(d8), .clock_output_fuse(cof),
    .factory_trim(ftrim), .port_pin_o(ppo), .port_pin_oe(ppoe), .clock_output_pin_o(pin_o),
    .clock_output_pin_oe(pin_oe), .cpu_clock_en(cpu_en), .flash_clock_en(fl_en), .io_clock_en(io_en),
    .converter_clock_en(cv_en), .trim_value(tval), .trim_range_bit(rbit), .trim_fine_value(tfine),
    .timer_osc_input_pin(osc), .timer_crystal_clock(xtal), .timer_clock_source(tsrc),
    .timer_external_clock_select(text));
  task automatic conclude();
    $display("Checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k == 50) begin
      error_cnt++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic setsel(input logic [7:0] v);
    apb(1, CTRL_ADDR, {24'h0, UNLOCK_KEY});
    apb(1, CTRL_ADDR, {24'h0, v});
  endtask
  // Waits for an enable pulse; slowest period is 256 cycles
  task automatic wait_en();
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      #1;
      k++;
    end while (cpu_en !== 1'b1 && k < 600);
    if (k == 600) begin
      error_cnt++;
      conclude();
    end
  endtask
  // Settles past the switch, then counts one period and its pin-high cycles
  task automatic measure();
    wait_en();
    wait_en();
    wait_en();
    n = 0;
    hi = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
      hi += (pin_o === 1'b1);
    end while (cpu_en !== 1'b1 && n < 600);
    chk({fl_en, io_en, cv_en}, {3{cpu_en}});
  endtask
  initial begin
    #1 chk(pin_oe, 1);
    repeat (3) @(posedge pclk);
    presetn <= 1;
    apb(0, CTRL_ADDR, 0);
    chk(rd, 32'h3);
    apb(0, TRIM_ADDR, 0);
    chk(rd, ftrim);
    measure();
    chk(32'(n), 8);
    for (int i = 0; i < 9; i++) begin
      setsel({4'h0, rows[i].sel});
      apb(0, CTRL_ADDR, 0);
      chk(rd, {28'h0, rows[i].sel});
      measure();
      chk(32'(n), 32'(rows[i].prd));
      chk(32'(hi), 32'(rows[i].hi));
    end
    apb(1, CTRL_ADDR, 32'h2);
    apb(1, CTRL_ADDR, 32'h81);
    apb(1, CTRL_ADDR, 32'h2);
    setsel(8'h80);
    apb(1, CTRL_ADDR, 32'h2);
    apb(0, CTRL_ADDR, 0);
    chk(rd, 32'h4);
    setsel(8'h7f);
    apb(0, CTRL_ADDR, 0);
    chk(rd, 32'hf);
    measure();
    chk(32'(n), 256);
    apb(1, 12'h000, 32'h5);
    chk(err, 1);
    apb(1, TRIM_ADDR, 32'h80);
    apb(0, TRIM_ADDR, 0);
    chk(rd, 32'h80);
    chk({rbit, tfine, tval}, 16'h8080);
    apb(1, TRIM_ADDR, 32'h7f);
    #1 chk({rbit, tfine}, 8'h7f);
    apb(1, ASYNC_ADDR, 32'h1);
    osc <= 1;
    xtal <= 0;
    @(posedge pclk);
    #1 chk({text, tsrc}, 2'b11);
    apb(1, ASYNC_ADDR, 32'h0);
    #1 chk({text, tsrc}, 2'b00);
    cof <= 0;
    ppo <= 1;
    @(posedge pclk);
    #1 chk({pin_o, pin_oe}, 2'b10);
    @(posedge pclk);
    presetn <= 0;
    d8 <= 0;
    cof <= 1;
    @(posedge pclk);
    #1 chk({pin_o, pin_oe}, 2'b01);
    @(posedge pclk);
    presetn <= 1;
    apb(0, CTRL_ADDR, 0);
    chk(rd, 32'h0);
    conclude();
  end
endmodule
